/* File: fss_pkg.sv */
// Constants, register map and field layout of the frame sync output shaping block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package fss_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned FRAME_PERIOD_NS    = 125000;
    localparam int unsigned MFRAME_PERIOD_NS   = 500000;
    localparam int unsigned FRAME_HALF_CYC     = FRAME_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned MFRAME_HALF_CYC    = MFRAME_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned CNT_W              = 16;
    localparam logic [15:0] CNT_IDLE           = 16'hFFFF;
    localparam logic [15:0] CNT_ONE            = 16'h0001;
    localparam logic [15:0] CNT_ZERO           = 16'h0000;
    localparam int unsigned FRAMES_PER_MF      = 4;
    localparam logic [1:0]  MF_DIV_LAST        = 2'h3;
    localparam logic [1:0]  MF_DIV_ONE         = 2'h1;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    localparam int unsigned ADDR_W             = 10;
    localparam int unsigned DATA_W             = 32;
    localparam logic [7:0]  IDX_PULSE_CFG      = 8'h7A;
    localparam logic [7:0]  IDX_PHASE_CFG      = 8'h7B;
    localparam logic [7:0]  IDX_STATUS         = 8'h7D;
    localparam logic [9:0]  ADDR_PULSE_CFG     = {IDX_PULSE_CFG, 2'b00};
    localparam logic [9:0]  ADDR_PHASE_CFG     = {IDX_PHASE_CFG, 2'b00};
    localparam logic [9:0]  ADDR_STATUS        = {IDX_STATUS, 2'b00};
    localparam logic [7:0]  PULSE_CFG_RESET    = 8'h00;
    localparam logic [7:0]  PHASE_CFG_RESET    = 8'h00;
    localparam logic [7:0]  PULSE_CFG_WMASK    = 8'h8F;
    localparam logic [31:0] RDATA_ZERO         = 32'h00000000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned BIT_SRC_SEL        = 7;
    localparam int unsigned BIT_FS_INV         = 3;
    localparam int unsigned BIT_FS_PULSE       = 2;
    localparam int unsigned BIT_MF_INV         = 1;
    localparam int unsigned BIT_MF_PULSE       = 0;
    localparam int unsigned BIT_INDEP_ALIGN    = 7;
    localparam int unsigned BIT_BYTE0          = 0;

    // Status register layout
    localparam int unsigned ST_FS_LEVEL        = 0;
    localparam int unsigned ST_MF_LEVEL        = 1;
    localparam int unsigned ST_O2_EN           = 2;
    localparam int unsigned ST_SRC_SEC         = 3;
    localparam int unsigned ST_EXT_LEVEL       = 4;

endpackage

/* File: fss_shape_if.sv */
// Carrier between the control logic and one sync output shaper.
// Assumes both ends share clk_sys_in.
`timescale 1ns/10ps
interface fss_shape_if;
    import fss_pkg::*;

    logic              start;
    logic              o2_tick;
    logic              o2_en;
    logic              pulse_mode;
    logic              invert;
    logic [CNT_W-1:0]  half_cycles;
    logic              level;

    modport ctrl (
        output start, o2_tick, o2_en, pulse_mode, invert, half_cycles,
        input  level
    );
    modport shaper (
        input  start, o2_tick, o2_en, pulse_mode, invert, half_cycles,
        output level
    );
endinterface

/* File: fss_shaper.sv */
// One sync output shaper: 50:50 square wave or one second-clock-period pulse, with polarity.
// Assumes start and o2_tick are single-cycle pulses in the clk_sys_in domain.
`timescale 1ns/10ps
module fss_shaper
    import fss_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_sys_in,
    input  wire logic  rst_in,
    // Shaping controls and level
    fss_shape_if.shaper sh
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             pulse_reg;
    logic             pulse_next;
    logic             level_reg;
    logic             level_next;
    logic             raw;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        cnt_next   = cnt_reg;
        pulse_next = pulse_reg;
        // Square wave: high for the first half period after each start
        if (sh.start) begin
            cnt_next = CNT_ZERO;
        end else if (cnt_reg < sh.half_cycles) begin
            cnt_next = cnt_reg + CNT_ONE;
        end
        // Pulse ends on the next second clock output period boundary
        if (sh.start) begin
            pulse_next = 1'b1;
        end else if (sh.o2_tick) begin
            pulse_next = 1'b0;
        end
        if (sh.pulse_mode) begin
            // No pulse at all while the second clock output is disabled
            raw = pulse_next & sh.o2_en;
        end else begin
            raw = (cnt_next < sh.half_cycles);
        end
        level_next = raw ^ sh.invert;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cnt_reg   <= CNT_IDLE;
            pulse_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            pulse_reg <= pulse_next;
            level_reg <= level_next;
        end
    end

    assign sh.level = level_reg;

endmodule

/* File: fss_top.sv */
// Frame sync (8 kHz) and multi-frame sync (2 kHz) output shaping with its register file.
// Assumes loop ticks come from logic on clk_sys_in; the external sync input is a pin.
`timescale 1ns/10ps

// Operation
// - Bit 7 of pulse config picks primary loop when clear, secondary when set.
// - Frame sync invert bit 3 set drives the 8 kHz output inverted.
// - Frame sync pulse bit 2 clear gives 50:50 square, set gives a pulse.
// - Pulsed frame sync needs second clock output; pulse lasts one of its periods.
// - Multi-frame invert bit 1 set drives the 2 kHz output inverted.
// - Multi-frame pulse bit 0 clear gives 50:50 square, set gives a pulse.
// - Pulsed multi-frame needs second clock output; pulse lasts one of its periods.
// - Phase bit 7 clear keeps sync aligned to clocks; set resyncs from sync input.
module fss_top
    import fss_pkg::*;
#(
    parameter logic [15:0] FRAME_HALF_CYCLES  = FRAME_HALF_CYC[15:0],
    parameter logic [15:0] MFRAME_HALF_CYCLES = MFRAME_HALF_CYC[15:0]
)
(
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic      [DATA_W-1:0] avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // Primary loop timing ticks
    input  wire logic              pri_frame_tick_in,
    input  wire logic              pri_mframe_tick_in,
    input  wire logic              pri_o2_tick_in,
    // Secondary loop timing ticks
    input  wire logic              sec_frame_tick_in,
    input  wire logic              sec_mframe_tick_in,
    input  wire logic              sec_o2_tick_in,
    // Second clock output state and external sync pin
    input  wire logic              o2_enable_in,
    input  wire logic              ext_sync_in,
    // Sync outputs
    output logic                   frame_sync_8k_out,
    output logic                   multiframe_sync_2k_out
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]        pulse_cfg_reg;
    logic [7:0]        pulse_cfg_next;
    logic [7:0]        phase_cfg_reg;
    logic [7:0]        phase_cfg_next;
    logic              wait_reg;
    logic              wait_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [7:0]        status_byte;
    logic [7:0]        wr_byte;
    logic              req;
    logic              do_write;

    // Control fields
    logic sync_source_select;
    logic frame_sync_polarity_flip;
    logic frame_sync_pulse_mode;
    logic multiframe_polarity_flip;
    logic multiframe_pulse_mode;
    logic independent_frame_align;

    assign sync_source_select       = pulse_cfg_reg[BIT_SRC_SEL];
    assign frame_sync_polarity_flip = pulse_cfg_reg[BIT_FS_INV];
    assign frame_sync_pulse_mode    = pulse_cfg_reg[BIT_FS_PULSE];
    assign multiframe_polarity_flip = pulse_cfg_reg[BIT_MF_INV];
    assign multiframe_pulse_mode    = pulse_cfg_reg[BIT_MF_PULSE];
    assign independent_frame_align  = phase_cfg_reg[BIT_INDEP_ALIGN];

    // ****************************************************************
    // External sync pin synchroniser
    // ****************************************************************
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic ext_level_reg;
    logic ext_level_next;
    logic ext_edge;

    always_comb begin
        // A change counts only once the second and third stages agree
        ext_level_next = ext_level_reg;
        if (ext_s2_reg == ext_s3_reg) begin
            ext_level_next = ext_s3_reg;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ext_s1_reg    <= 1'b0;
            ext_s2_reg    <= 1'b0;
            ext_s3_reg    <= 1'b0;
            ext_level_reg <= 1'b0;
        end else begin
            ext_s1_reg    <= ext_sync_in;
            ext_s2_reg    <= ext_s1_reg;
            ext_s3_reg    <= ext_s2_reg;
            ext_level_reg <= ext_level_next;
        end
    end

    assign ext_edge = ext_level_next & ~ext_level_reg;

    // ****************************************************************
    // Source selection and alignment
    // ****************************************************************
    logic       loop_frame_tick;
    logic       loop_mframe_tick;
    logic       loop_o2_tick;
    logic       frame_start;
    logic       mframe_start;
    logic [1:0] mf_div_reg;
    logic [1:0] mf_div_next;

    always_comb begin
        // Both sync outputs and the second clock come from one loop
        if (sync_source_select) begin
            loop_frame_tick  = sec_frame_tick_in;
            loop_mframe_tick = sec_mframe_tick_in;
            loop_o2_tick     = sec_o2_tick_in;
        end else begin
            loop_frame_tick  = pri_frame_tick_in;
            loop_mframe_tick = pri_mframe_tick_in;
            loop_o2_tick     = pri_o2_tick_in;
        end
    end

    always_comb begin
        mf_div_next = mf_div_reg;
        if (independent_frame_align) begin
            // Frames follow the sync input; every fourth edge opens a multi-frame.
            // Other output clocks keep running untouched.
            frame_start  = ext_edge;
            mframe_start = ext_edge & (mf_div_reg == 2'h0);
            if (ext_edge) begin
                mf_div_next = (mf_div_reg == MF_DIV_LAST) ? 2'h0 : mf_div_reg + MF_DIV_ONE;
            end
        end else begin
            // Locked to the loop's own clock edges, so always aligned
            frame_start  = loop_frame_tick;
            mframe_start = loop_mframe_tick;
            mf_div_next  = 2'h0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            mf_div_reg <= 2'h0;
        end else begin
            mf_div_reg <= mf_div_next;
        end
    end

    // ****************************************************************
    // Output shapers
    // ****************************************************************
    fss_shape_if fs_if ();
    fss_shape_if mf_if ();

    assign fs_if.start       = frame_start;
    assign fs_if.o2_tick     = loop_o2_tick;
    assign fs_if.o2_en       = o2_enable_in;
    assign fs_if.pulse_mode  = frame_sync_pulse_mode;
    assign fs_if.invert      = frame_sync_polarity_flip;
    assign fs_if.half_cycles = FRAME_HALF_CYCLES;

    assign mf_if.start       = mframe_start;
    assign mf_if.o2_tick     = loop_o2_tick;
    assign mf_if.o2_en       = o2_enable_in;
    assign mf_if.pulse_mode  = multiframe_pulse_mode;
    assign mf_if.invert      = multiframe_polarity_flip;
    assign mf_if.half_cycles = MFRAME_HALF_CYCLES;

    fss_shaper u_fs_shaper (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .sh         (fs_if.shaper)
    );

    fss_shaper u_mf_shaper (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .sh         (mf_if.shaper)
    );

    assign frame_sync_8k_out      = fs_if.level;
    assign multiframe_sync_2k_out = mf_if.level;

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    // One wait cycle on every access keeps read data a clean register output
    assign req      = avs_read_in | avs_write_in;
    assign do_write = avs_write_in & ~wait_reg & avs_byteenable_in[BIT_BYTE0];
    assign wr_byte  = avs_writedata_in[7:0];

    always_comb begin
        status_byte               = 8'h00;
        status_byte[ST_FS_LEVEL]  = fs_if.level;
        status_byte[ST_MF_LEVEL]  = mf_if.level;
        status_byte[ST_O2_EN]     = o2_enable_in;
        status_byte[ST_SRC_SEC]   = sync_source_select;
        status_byte[ST_EXT_LEVEL] = ext_level_reg;
    end

    always_comb begin
        wait_next      = 1'b1;
        rdata_next     = rdata_reg;
        pulse_cfg_next = pulse_cfg_reg;
        phase_cfg_next = phase_cfg_reg;
        if (req && wait_reg) begin
            wait_next  = 1'b0;
            rdata_next = RDATA_ZERO;
            if (avs_read_in) begin
                unique case (avs_address_in)
                    ADDR_PULSE_CFG: rdata_next[7:0] = pulse_cfg_reg & PULSE_CFG_WMASK;
                    ADDR_PHASE_CFG: rdata_next[7:0] = phase_cfg_reg;
                    ADDR_STATUS:    rdata_next[7:0] = status_byte;
                    default:        rdata_next      = RDATA_ZERO;
                endcase
            end
        end
        if (do_write) begin
            unique case (avs_address_in)
                ADDR_PULSE_CFG: pulse_cfg_next = wr_byte & PULSE_CFG_WMASK;
                ADDR_PHASE_CFG: phase_cfg_next = wr_byte;
                default:        pulse_cfg_next = pulse_cfg_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wait_reg      <= 1'b1;
            rdata_reg     <= RDATA_ZERO;
            pulse_cfg_reg <= PULSE_CFG_RESET;
            phase_cfg_reg <= PHASE_CFG_RESET;
        end else begin
            wait_reg      <= wait_next;
            rdata_reg     <= rdata_next;
            pulse_cfg_reg <= pulse_cfg_next;
            phase_cfg_reg <= phase_cfg_next;
        end
    end

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;

endmodule

/* File: fss_top_checker.sv */
// Concurrent checks on the sync output shaping top: bus handshake, read data, sync output starts.
// Assumes it is bound into fss_top and sees only that module's ports.
`timescale 1ns/10ps
module fss_top_checker
    import fss_pkg::*;
(
    // Clock, reset and bus
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    input  wire logic [DATA_W-1:0] avs_readdata_out,
    input  wire logic              avs_waitrequest_out,
    // Ticks and outputs
    input  wire logic              pri_frame_tick_in,
    input  wire logic              pri_mframe_tick_in,
    input  wire logic              pri_o2_tick_in,
    input  wire logic              sec_frame_tick_in,
    input  wire logic              sec_mframe_tick_in,
    input  wire logic              sec_o2_tick_in,
    input  wire logic              o2_enable_in,
    input  wire logic              frame_sync_8k_out,
    input  wire logic              multiframe_sync_2k_out
);
    // ****************************************************************
    // Shadow of the configuration, rebuilt from completed writes
    // ****************************************************************
    logic [7:0] cfg_reg, cfg_next;
    logic       al_reg, al_next;
    logic       wr_done, ft, mt, ot, rd_done;

    assign wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    assign rd_done = avs_read_in && !avs_waitrequest_out;
    assign ft      = cfg_reg[7] ? sec_frame_tick_in : pri_frame_tick_in;
    assign mt      = cfg_reg[7] ? sec_mframe_tick_in : pri_mframe_tick_in;
    assign ot      = cfg_reg[7] ? sec_o2_tick_in : pri_o2_tick_in;

    always_comb begin
        cfg_next = cfg_reg;
        al_next  = al_reg;
        if (wr_done && avs_address_in == ADDR_PULSE_CFG) begin
            cfg_next = avs_writedata_in[7:0] & 8'h8F;
        end
        if (wr_done && avs_address_in == ADDR_PHASE_CFG) begin
            al_next = avs_writedata_in[7];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_reg <= 8'h00;
            al_reg  <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            al_reg  <= al_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest did not drop one cycle after a request");
    chk_wait_one: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest stayed low for more than one cycle");
    chk_reserved_zero: assert property (rd_done && avs_address_in == ADDR_PULSE_CFG |-> avs_readdata_out[6:4] == 3'h0)
        else $error("unused pulse config bits read nonzero");
    chk_unmapped_zero: assert property (rd_done && avs_address_in != ADDR_PULSE_CFG && avs_address_in != ADDR_PHASE_CFG
        && avs_address_in != ADDR_STATUS |-> avs_readdata_out == 32'h00000000)
        else $error("unmapped read returned nonzero");
    chk_fs_square: assert property (!al_reg && ft && cfg_reg[3:2] == 2'b00 |=> frame_sync_8k_out)
        else $error("frame sync square did not start high");
    chk_fs_invert: assert property (!al_reg && ft && cfg_reg[3:2] == 2'b10 |=> !frame_sync_8k_out)
        else $error("inverted frame sync did not start low");
    chk_fs_pulse_end: assert property (!al_reg && ot && !ft && cfg_reg[3:2] == 2'b01 |=> !frame_sync_8k_out)
        else $error("frame sync pulse outlived the second clock period");
    chk_mf_pulse: assert property (!al_reg && mt && o2_enable_in && $past(o2_enable_in) && cfg_reg[1:0] == 2'b01
        |=> multiframe_sync_2k_out)
        else $error("multiframe pulse did not start");
    chk_mf_invert: assert property (!al_reg && mt && cfg_reg[1:0] == 2'b10 |=> !multiframe_sync_2k_out)
        else $error("inverted multiframe square did not start low");
endmodule

bind fss_top fss_top_checker u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pri_frame_tick_in(pri_frame_tick_in),
    .pri_mframe_tick_in(pri_mframe_tick_in), .pri_o2_tick_in(pri_o2_tick_in), .sec_frame_tick_in(sec_frame_tick_in),
    .sec_mframe_tick_in(sec_mframe_tick_in), .sec_o2_tick_in(sec_o2_tick_in), .o2_enable_in(o2_enable_in),
    .frame_sync_8k_out(frame_sync_8k_out), .multiframe_sync_2k_out(multiframe_sync_2k_out));

/* File: test_frame_sync_output_shaping.sv */
// Self-checking bench for the sync output shaping top: registers, modes, loop select, alignment.
// Assumes fss_top with shortened half periods and a 100 MHz clock.
`timescale 1ns/10ps
module test_frame_sync_output_shaping;
    import fss_pkg::*;
    localparam int FH = 8;
    localparam int MH = 32;
    logic        clk_sys_in, avs_waitrequest_out, frame_sync_8k_out, multiframe_sync_2k_out, exp_fs, exp_mf;
    logic        rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0, o2_enable_in = 1'b1, ext_sync_in = 1'b0;
    logic        pri_frame_tick_in = 1'b0, pri_mframe_tick_in = 1'b0, pri_o2_tick_in = 1'b0;
    logic        sec_frame_tick_in = 1'b0, sec_mframe_tick_in = 1'b0, sec_o2_tick_in = 1'b0;
    logic        run = 1'b0, al_sh = 1'b0, ok_fs = 1'b0, ok_mf = 1'b0;
    logic [9:0]  avs_address_in = 10'h000, sig_prev = 10'h000;
    logic [3:0]  avs_byteenable_in = 4'hF;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q, seed = 32'hF529;
    logic [7:0]  cfg_sh = 8'h00;
    int          n_errors = 0, tests_run = 0, fc = 0, mc = 0, fp = 0, mp = 0;

    fss_top #(.FRAME_HALF_CYCLES(16'h0008), .MFRAME_HALF_CYCLES(16'h0020)) u_dut (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .pri_frame_tick_in(pri_frame_tick_in),
        .pri_mframe_tick_in(pri_mframe_tick_in), .pri_o2_tick_in(pri_o2_tick_in), .sec_frame_tick_in(sec_frame_tick_in),
        .sec_mframe_tick_in(sec_mframe_tick_in), .sec_o2_tick_in(sec_o2_tick_in), .o2_enable_in(o2_enable_in),
        .ext_sync_in(ext_sync_in), .frame_sync_8k_out(frame_sync_8k_out),
        .multiframe_sync_2k_out(multiframe_sync_2k_out));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_sync(input string nm, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %s expected %b seen %b", nm, e, s);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        n = 0;
        // Waitrequest and read data are taken at the rising edge itself, before the design updates them
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (avs_waitrequest_out !== 1'b0) begin
            chk_reg("bus timeout", 32'h0, 32'h1);
            report_and_stop();
        end
        q = avs_readdata_out;
        if (wr && a == ADDR_PULSE_CFG) cfg_sh <= d[7:0] & 8'h8F;
        if (wr && a == ADDR_PHASE_CFG) al_sh <= d[7];
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    // ****************************************************************
    // Stimulus, model and comparison
    // ****************************************************************
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        logic [31:0] r;
        r = rnd();
        pri_frame_tick_in  <= run && r[4:0] == 5'h00;
        sec_frame_tick_in  <= run && r[9:5] == 5'h00;
        pri_mframe_tick_in <= run && r[15:10] == 6'h00;
        sec_mframe_tick_in <= run && r[21:16] == 6'h00;
        pri_o2_tick_in     <= run && r[23:22] == 2'h0;
        sec_o2_tick_in     <= run && r[25:24] == 2'h0;
    end

    // Model is only trusted after a fresh start, as a mode change leaves shaper state open
    always @(posedge clk_sys_in) begin
        logic f, m, o;
        f = cfg_sh[7] ? sec_frame_tick_in : pri_frame_tick_in;
        m = cfg_sh[7] ? sec_mframe_tick_in : pri_mframe_tick_in;
        o = cfg_sh[7] ? sec_o2_tick_in : pri_o2_tick_in;
        ok_fs <= (rst_in || {al_sh, o2_enable_in, cfg_sh} != sig_prev) ? 1'b0 : (ok_fs || f);
        ok_mf <= (rst_in || {al_sh, o2_enable_in, cfg_sh} != sig_prev) ? 1'b0 : (ok_mf || m);
        sig_prev <= {al_sh, o2_enable_in, cfg_sh};
        fc = f ? FH : (fc > 0 ? fc - 1 : 0);
        mc = m ? MH : (mc > 0 ? mc - 1 : 0);
        fp = f ? 1 : (o ? 0 : fp);
        mp = m ? 1 : (o ? 0 : mp);
        exp_fs <= cfg_sh[3] ^ (cfg_sh[2] ? (fp == 1 && o2_enable_in) : fc > 0);
        exp_mf <= cfg_sh[1] ^ (cfg_sh[0] ? (mp == 1 && o2_enable_in) : mc > 0);
    end

    always @(negedge clk_sys_in) begin
        if (ok_fs && !al_sh) chk_sync("frame_sync_8k_out", exp_fs, frame_sync_8k_out);
        if (ok_mf && !al_sh) chk_sync("multiframe_sync_2k_out", exp_mf, multiframe_sync_2k_out);
    end

    initial begin
        repeat (100000) @(posedge clk_sys_in);
        chk_reg("watchdog", 32'h0, 32'h1);
        report_and_stop();
    end

    initial begin
        int m, k, n;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        bus(1'b0, ADDR_PULSE_CFG, 32'h0);
        chk_reg("pulse config reset", 32'h0, q);
        bus(1'b0, ADDR_PHASE_CFG, 32'h0);
        chk_reg("phase config reset", 32'h0, q);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk_reg("status after reset", 32'h1 << ST_O2_EN, q);
        bus(1'b1, ADDR_PULSE_CFG, 32'hFF);
        bus(1'b0, ADDR_PULSE_CFG, 32'h0);
        chk_reg("pulse config unused bits", 32'h8F, q);
        bus(1'b1, ADDR_PHASE_CFG, 32'h7F);
        bus(1'b0, ADDR_PHASE_CFG, 32'h0);
        chk_reg("phase config", 32'h7F, q);
        bus(1'b1, 10'h000, 32'hFF);
        bus(1'b0, 10'h000, 32'h0);
        chk_reg("unmapped read", 32'h0, q);
        $display("register test done");
        run <= 1'b1;
        for (m = 0; m < 32; m++) begin
            bus(1'b1, ADDR_PULSE_CFG, {24'h0, m[4], 3'h0, m[3:0]});
            o2_enable_in <= (m % 8) != 7;
            repeat (300) @(posedge clk_sys_in);
        end
        $display("shaping test done");
        bus(1'b1, ADDR_PULSE_CFG, 32'h0);
        bus(1'b1, ADDR_PHASE_CFG, 32'h80);
        repeat (60) @(posedge clk_sys_in);
        for (k = 0; k < 5; k++) begin
            ext_sync_in <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_sys_in);
                #1;
                n++;
            end while (frame_sync_8k_out !== 1'b1 && n < 12);
            chk_reg("align delay", 32'd4, n);
            chk_sync("align multiframe", k % 4 == 0, multiframe_sync_2k_out);
            @(posedge clk_sys_in);
            ext_sync_in <= 1'b0;
            repeat (45) @(posedge clk_sys_in);
        end
        run <= 1'b0;
        $display("alignment test done");
        report_and_stop();
    end
endmodule
